// File: logic/breaker_standard_dataset_regs.sv
// read-only breaker dataset register bank served to a remote master
//
// Summary of operation
// RULE_01: seconds count split in two words, high word first.
// RULE_02: milliseconds in the low ten bits of word three.
// RULE_03: timestamp at registers 2900 to 2902, quality bits in 2902.
// RULE_04: master reads one register per 16-bit value, two per 32-bit.
// RULE_05: partial read of the energy block is refused.
// RULE_06: any unmapped register read gets an exception.
// RULE_07: neutral-dependent values read 32768 without neutral.
// RULE_08: out-of-order values use a fixed code per data type.
// RULE_09: standard dataset occupies registers 32000 through 32341.
// RULE_10: master asks at most 125 registers per read.
// RULE_11: modules push data into a local copy serving all reads; timestamp, system type and status words bypass it.
// RULE_12: voltage, current, power and power factor refresh every second.
// RULE_13: energy and min/max values refresh every five seconds.
// RULE_14: each bit of 32000 marks validity of the same bit of 32001.
// RULE_15: status bit 0 follows the position contact, 1 means closed.
// RULE_16: status bit 1 shows a trip, forced 0 on motor breakers.
// RULE_17: status bit 2 shows only an electrical fault trip.
// RULE_18: millisecond word bits 12, 13, 14 give sync and date-set flags.
// RULE_19: seconds restart at zero on power-up, load on external sync.
// RULE_20: writes are refused with an exception, nothing changes.
`timescale 1ns/1ps
module breaker_standard_dataset_regs #(
   parameter int CYCLES_PER_MS = breaker_pkg::CYCLES_PER_MS
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // master request
   input wire logic req_valid,
   input wire logic [7:0] req_func,
   input wire logic [15:0] req_addr,
   input wire logic [15:0] req_count,
   output logic req_ready,
   // master answer
   output logic rsp_valid,
   output logic [15:0] rsp_data,
   output logic rsp_last,
   output logic rsp_exc,
   output logic [7:0] rsp_exc_code,
   // module link pushes
   input wire logic upd_valid,
   input wire logic [8:0] upd_index,
   input wire logic [15:0] upd_data,
   input wire breaker_pkg::data_type_t upd_type,
   input wire logic upd_low_word,
   input wire logic upd_out_of_order,
   // time synchronisation
   input wire logic ext_sync,
   input wire logic [31:0] ext_sync_seconds,
   input wire logic int_sync,
   // configuration
   input wire logic [15:0] sys_type,
   // breaker contact pins
   input wire logic position_contact,
   input wire logic trip_contact,
   input wire logic fault_trip_contact,
   input wire logic [2:0] contact_valid,
   input wire logic motor_mechanism
);

   ////////////////
   // state

   typedef struct packed {
      breaker_pkg::engine_state_t st;
      logic [15:0] addr;
      logic [6:0] left;
      logic [8:0] rd_index;
      logic [15:0] ts_hi;
      logic [15:0] ts_lo;
      logic [15:0] ts_ms;
      logic req_ready;
      logic rsp_valid;
      logic [15:0] rsp_data;
      logic rsp_last;
      logic rsp_exc;
      logic [7:0] rsp_exc_code;
      logic [6:0] pin_meta;
      logic [6:0] pin_sync;
      logic [15:0] status;
      logic [15:0] quality;
   } regs_state_t;

   regs_state_t s;
   regs_state_t next_s;

   logic [31:0] seconds;
   logic [9:0] millis;
   logic ext_synced;
   logic int_synced;
   logic date_set;
   logic tick_fast;
   logic tick_slow;
   logic [15:0] store_word;

   logic [6:0] pins_raw;
   logic [16:0] req_end;
   logic is_read;
   logic in_ts;
   logic in_sys;
   logic in_ds;
   logic touch_energy;
   logic whole_energy;
   logic [7:0] exc_code;
   logic [15:0] ms_word;
   logic [15:0] word;
   logic in_neutral;

   ////////////////
   // leaf blocks

   seconds_clock #(
      .CYCLES_PER_MS(CYCLES_PER_MS)
   ) u_clock (
      .clk(clk),
      .reset_n(reset_n),
      .ext_sync(ext_sync),
      .ext_sync_seconds(ext_sync_seconds),
      .int_sync(int_sync),
      .seconds(seconds),
      .millis(millis),
      .ext_synced(ext_synced),
      .int_synced(int_synced),
      .date_set(date_set),
      .tick_fast(tick_fast),
      .tick_slow(tick_slow)
   );

   // RULE_11: reads served from local copy
   dataset_store #(
      .WORDS(breaker_pkg::DS_WORDS),
      .IDX_W(breaker_pkg::DS_INDEX_W)
   ) u_store (
      .clk(clk),
      .reset_n(reset_n),
      .wr_valid(upd_valid),
      .wr_index(upd_index),
      .wr_data(upd_data),
      .wr_type(upd_type),
      .wr_low_word(upd_low_word),
      .wr_out_of_order(upd_out_of_order),
      .commit_fast(tick_fast),
      .commit_slow(tick_slow),
      .rd_index(s.rd_index),
      .rd_data(store_word)
   );

   ////////////////
   // request checks

   always_comb begin
      pins_raw = {motor_mechanism, contact_valid, fault_trip_contact,
                  trip_contact, position_contact};

      req_end = {1'b0, req_addr} + {1'b0, req_count} - 17'h00001;
      is_read = (req_func == breaker_pkg::FC_READ_HOLDING)
                || (req_func == breaker_pkg::FC_READ_INPUT);

      // RULE_03: timestamp window
      in_ts = (req_addr >= breaker_pkg::TS_SEC_HI_ADDR)
              && (req_end <= {1'b0, breaker_pkg::TS_MS_ADDR});
      in_sys = (req_addr == breaker_pkg::SYS_TYPE_ADDR)
               && (req_end == {1'b0, breaker_pkg::SYS_TYPE_ADDR});

      // RULE_09: dataset window
      in_ds = (req_addr >= breaker_pkg::DS_FIRST_ADDR)
              && (req_end <= {1'b0, breaker_pkg::DS_LAST_ADDR});
      touch_energy = (req_addr <= breaker_pkg::ENERGY_LAST_ADDR)
                     && (req_end >= {1'b0, breaker_pkg::ENERGY_FIRST_ADDR});
      whole_energy = (req_addr <= breaker_pkg::ENERGY_FIRST_ADDR)
                     && (req_end >= {1'b0, breaker_pkg::ENERGY_LAST_ADDR});

      exc_code = 8'h00;
      // RULE_20: writes refused
      if (!is_read) begin
         exc_code = breaker_pkg::EXC_ILLEGAL_FUNCTION;
      end else if ((req_count == 16'h0000) || (req_count > breaker_pkg::MAX_READ_WORDS)) begin
         // over-long read is malformed
         exc_code = breaker_pkg::EXC_ILLEGAL_VALUE;
      // RULE_06: unmapped registers
      end else if (!(in_ts || in_sys || in_ds)) begin
         exc_code = breaker_pkg::EXC_ILLEGAL_ADDRESS;
      // RULE_05: partial energy block
      end else if (touch_energy && !whole_energy) begin
         exc_code = breaker_pkg::EXC_ILLEGAL_ADDRESS;
      end
   end

   ////////////////
   // word selection

   always_comb begin
      // RULE_02: millisecond field
      ms_word = {6'h00, millis} & breaker_pkg::MS_MASK;
      // RULE_18: quality flags
      ms_word[breaker_pkg::MS_EXT_SYNC_BIT] = ext_synced;
      ms_word[breaker_pkg::MS_INT_SYNC_BIT] = int_synced;
      ms_word[breaker_pkg::MS_DATE_SET_BIT] = date_set;

      in_neutral = (s.addr >= breaker_pkg::NEUTRAL_FIRST_ADDR)
                   && (s.addr <= breaker_pkg::NEUTRAL_LAST_ADDR);

      word = store_word;
      if (s.addr == breaker_pkg::TS_SEC_HI_ADDR) begin
         word = s.ts_hi;
      end else if (s.addr == breaker_pkg::TS_SEC_LO_ADDR) begin
         word = s.ts_lo;
      end else if (s.addr == breaker_pkg::TS_MS_ADDR) begin
         word = s.ts_ms;
      end else if (s.addr == breaker_pkg::SYS_TYPE_ADDR) begin
         word = sys_type;
      end else if (s.addr == breaker_pkg::BREAKER_STATUS_QUALITY_ADDR) begin
         word = s.quality;
      end else if (s.addr == breaker_pkg::BREAKER_STATUS_ADDR) begin
         word = s.status;
      // RULE_07: no neutral means not applicable
      end else if (in_neutral && !sys_type[breaker_pkg::SYS_TYPE_NEUTRAL_BIT]) begin
         word = breaker_pkg::NEUTRAL_NA;
      end
   end

   ////////////////
   // next state

   always_comb begin
      next_s = s;
      next_s.rsp_valid = 1'b0;
      next_s.rsp_last = 1'b0;
      next_s.rsp_exc = 1'b0;
      // contact pins pass two flops before use
      next_s.pin_meta = pins_raw;
      next_s.pin_sync = s.pin_meta;

      next_s.status = 16'h0000;
      // RULE_15: position contact
      next_s.status[breaker_pkg::POS_BIT] = s.pin_sync[0];
      // RULE_16: trip contact, blanked on motor breakers
      next_s.status[breaker_pkg::TRIP_BIT] = s.pin_sync[1] & ~s.pin_sync[6];
      // RULE_17: fault trip contact
      next_s.status[breaker_pkg::FAULT_BIT] = s.pin_sync[2];
      // RULE_14: per-bit validity
      next_s.quality = {13'h0000, s.pin_sync[5:3]};

      case (s.st)
         breaker_pkg::ENG_IDLE: begin
            if (req_valid && s.req_ready) begin
               if (exc_code != 8'h00) begin
                  next_s.rsp_valid = 1'b1;
                  next_s.rsp_last = 1'b1;
                  next_s.rsp_exc = 1'b1;
                  next_s.rsp_exc_code = exc_code;
               end else begin
                  next_s.st = breaker_pkg::ENG_SEND;
                  next_s.req_ready = 1'b0;
                  next_s.addr = req_addr;
                  next_s.left = req_count[6:0];
                  next_s.rd_index = 9'(req_addr - breaker_pkg::DS_FIRST_ADDR);
                  // RULE_01: snapshot keeps both halves coherent
                  next_s.ts_hi = seconds[31:16];
                  next_s.ts_lo = seconds[15:0];
                  next_s.ts_ms = ms_word;
               end
            end
         end
         breaker_pkg::ENG_SEND: begin
            next_s.rsp_valid = 1'b1;
            next_s.rsp_data = word;
            next_s.addr = s.addr + 16'h0001;
            next_s.rd_index = s.rd_index + 9'h001;
            next_s.left = s.left - 7'h01;
            if (s.left == 7'h01) begin
               next_s.rsp_last = 1'b1;
               next_s.req_ready = 1'b1;
               next_s.st = breaker_pkg::ENG_IDLE;
            end
         end
         default: begin
            next_s.st = breaker_pkg::ENG_IDLE;
            next_s.req_ready = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s <= '{st: breaker_pkg::ENG_IDLE, req_ready: 1'b1, default: '0};
      end else begin
         s <= next_s;
      end
   end

   ////////////////
   // outputs

   assign req_ready = s.req_ready;
   assign rsp_valid = s.rsp_valid;
   assign rsp_data = s.rsp_data;
   assign rsp_last = s.rsp_last;
   assign rsp_exc = s.rsp_exc;
   assign rsp_exc_code = s.rsp_exc_code;
endmodule

// File: logic/breaker_pkg.sv
// shared constants and types for the breaker dataset register bank
package breaker_pkg;
   // protocol addresses, one below the printed register number
   localparam logic [15:0] TS_SEC_HI_ADDR = 16'h0b53;
   localparam logic [15:0] TS_SEC_LO_ADDR = 16'h0b54;
   localparam logic [15:0] TS_MS_ADDR = 16'h0b55;
   localparam logic [15:0] SYS_TYPE_ADDR = 16'h0cf1;
   localparam logic [15:0] BREAKER_STATUS_QUALITY_ADDR = 16'h7cff;
   localparam logic [15:0] BREAKER_STATUS_ADDR = 16'h7d00;
   localparam logic [15:0] DS_FIRST_ADDR = 16'h7cff;
   localparam logic [15:0] DS_LAST_ADDR = 16'h7e54;
   localparam logic [15:0] ENERGY_FIRST_ADDR = 16'h7d63;
   localparam logic [15:0] ENERGY_LAST_ADDR = 16'h7d6e;
   localparam logic [15:0] NEUTRAL_FIRST_ADDR = 16'h7d0f;
   localparam logic [15:0] NEUTRAL_LAST_ADDR = 16'h7d12;
   localparam int SYS_TYPE_NEUTRAL_BIT = 0;
   // dataset storage, as word index from the first dataset address
   localparam int DS_WORDS = 342;
   localparam int DS_INDEX_W = 9;
   localparam logic [8:0] SLOW_FIRST_IDX = 9'h064;
   localparam logic [8:0] SLOW_LAST_IDX = 9'h0ff;
   // request handling
   localparam logic [15:0] MAX_READ_WORDS = 16'h007d;
   localparam logic [7:0] FC_READ_HOLDING = 8'h03;
   localparam logic [7:0] FC_READ_INPUT = 8'h04;
   localparam logic [7:0] EXC_ILLEGAL_FUNCTION = 8'h01;
   localparam logic [7:0] EXC_ILLEGAL_ADDRESS = 8'h02;
   localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
   // field positions
   localparam logic [15:0] MS_MASK = 16'h03ff;
   localparam int MS_EXT_SYNC_BIT = 12;
   localparam int MS_INT_SYNC_BIT = 13;
   localparam int MS_DATE_SET_BIT = 14;
   localparam int POS_BIT = 0;
   localparam int TRIP_BIT = 1;
   localparam int FAULT_BIT = 2;
   // not-applicable codes
   localparam logic [15:0] NA_U16 = 16'hffff;
   localparam logic [15:0] NA_S16 = 16'h8000;
   localparam logic [15:0] NEUTRAL_NA = 16'h8000;
   localparam logic [31:0] NA_S32 = 32'h8000_0000;
   localparam logic [31:0] NA_F32 = 32'hffc0_0000;
   localparam logic [31:0] SECONDS_RESET = 32'h0000_0000;
   // timing
   localparam int CLK_PERIOD_PS = 5000;
   localparam int MS_PERIOD_PS = 1000000000;
   localparam int CYCLES_PER_MS = MS_PERIOD_PS / CLK_PERIOD_PS;
   localparam int MS_PER_S = 1000;
   localparam int SLOW_PERIOD_S = 5;
   localparam int EXT_SYNC_HOLD_S = 7200;
   typedef enum logic [1:0] {DT_U16, DT_S16, DT_S32, DT_F32} data_type_t;
   typedef enum logic [0:0] {ENG_IDLE, ENG_SEND} engine_state_t;
endpackage

// File: logic/seconds_clock.sv
// seconds-since-2000 counter, sync flags and refresh ticks
`timescale 1ns/1ps
module seconds_clock #(
   parameter int CYCLES_PER_MS = breaker_pkg::CYCLES_PER_MS
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // synchronisation events
   input wire logic ext_sync,
   input wire logic [31:0] ext_sync_seconds,
   input wire logic int_sync,
   // time and ticks
   output logic [31:0] seconds,
   output logic [9:0] millis,
   output logic ext_synced,
   output logic int_synced,
   output logic date_set,
   output logic tick_fast,
   output logic tick_slow
);
   localparam int DIV_W = $clog2(CYCLES_PER_MS + 1);
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CYCLES_PER_MS - 1);
   localparam logic [9:0] MS_LAST = 10'(breaker_pkg::MS_PER_S - 1);
   localparam logic [2:0] SLOW_LAST = 3'(breaker_pkg::SLOW_PERIOD_S - 1);
   localparam logic [12:0] HOLD_LAST = 13'(breaker_pkg::EXT_SYNC_HOLD_S - 1);

   typedef struct packed {
      logic [DIV_W-1:0] div;
      logic [9:0] ms;
      logic [31:0] sec;
      logic [2:0] slow;
      logic [12:0] age;
      logic ext;
      logic intl;
      logic set;
      logic fast_tick;
      logic slow_tick;
   } clock_state_t;

   clock_state_t s;
   clock_state_t next_s;
   logic ms_end;
   logic sec_end;

   always_comb begin
      next_s = s;
      next_s.fast_tick = 1'b0;
      next_s.slow_tick = 1'b0;
      ms_end = (s.div == DIV_LAST);
      sec_end = ms_end && (s.ms == MS_LAST);
      next_s.div = ms_end ? '0 : s.div + 1'b1;
      if (ms_end) begin
         next_s.ms = sec_end ? '0 : s.ms + 10'h001;
      end
      if (sec_end) begin
         next_s.sec = s.sec + 32'h0000_0001;
         // RULE_12: one second tick
         next_s.fast_tick = 1'b1;
         // RULE_13: five second tick
         next_s.slow_tick = (s.slow == SLOW_LAST);
         next_s.slow = (s.slow == SLOW_LAST) ? '0 : s.slow + 3'h1;
         // RULE_18: external sync ages out
         if (s.age == HOLD_LAST) begin
            next_s.ext = 1'b0;
         end else begin
            next_s.age = s.age + 13'h0001;
         end
      end
      if (int_sync) begin
         next_s.intl = 1'b1;
      end
      // RULE_19: load converted date
      if (ext_sync) begin
         next_s.sec = ext_sync_seconds;
         next_s.ms = '0;
         next_s.div = '0;
         next_s.age = '0;
         next_s.ext = 1'b1;
         next_s.set = 1'b1;
      end
   end

   // RULE_19: power-up restarts at zero
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s <= '{sec: breaker_pkg::SECONDS_RESET, default: '0};
      end else begin
         s <= next_s;
      end
   end

   assign seconds = s.sec;
   assign millis = s.ms;
   assign ext_synced = s.ext;
   assign int_synced = s.intl;
   assign date_set = s.set;
   assign tick_fast = s.fast_tick;
   assign tick_slow = s.slow_tick;
endmodule

// File: logic/dataset_store.sv
// local copy of the standard dataset, staged and published by class
`timescale 1ns/1ps
module dataset_store #(
   parameter int WORDS = breaker_pkg::DS_WORDS,
   parameter int IDX_W = breaker_pkg::DS_INDEX_W
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // pushes from measurement modules
   input wire logic wr_valid,
   input wire logic [IDX_W-1:0] wr_index,
   input wire logic [15:0] wr_data,
   input wire breaker_pkg::data_type_t wr_type,
   input wire logic wr_low_word,
   input wire logic wr_out_of_order,
   // publish strobes
   input wire logic commit_fast,
   input wire logic commit_slow,
   // lookup
   input wire logic [IDX_W-1:0] rd_index,
   output logic [15:0] rd_data
);
   typedef struct packed {
      logic [WORDS-1:0][15:0] stage;
      logic [WORDS-1:0] pend;
      logic [WORDS-1:0][15:0] shown;
   } store_state_t;

   store_state_t s;
   store_state_t next_s;
   logic [15:0] push_word;
   logic slow_class;

   always_comb begin
      next_s = s;
      push_word = wr_data;
      slow_class = 1'b0;
      // RULE_08: per-type out-of-order code
      if (wr_out_of_order) begin
         case (wr_type)
            breaker_pkg::DT_U16: push_word = breaker_pkg::NA_U16;
            breaker_pkg::DT_S16: push_word = breaker_pkg::NA_S16;
            breaker_pkg::DT_S32: begin
               push_word = wr_low_word ? breaker_pkg::NA_S32[15:0] : breaker_pkg::NA_S32[31:16];
            end
            breaker_pkg::DT_F32: begin
               push_word = wr_low_word ? breaker_pkg::NA_F32[15:0] : breaker_pkg::NA_F32[31:16];
            end
            default: push_word = breaker_pkg::NA_U16;
         endcase
      end
      // RULE_12: fast class publishes each second
      // RULE_13: slow class publishes each five seconds
      for (int i = 0; i < WORDS; i++) begin
         slow_class = (i >= int'(breaker_pkg::SLOW_FIRST_IDX))
                      && (i <= int'(breaker_pkg::SLOW_LAST_IDX));
         if (s.pend[i] && (slow_class ? commit_slow : commit_fast)) begin
            next_s.shown[i] = s.stage[i];
            next_s.pend[i] = 1'b0;
         end
      end
      // RULE_11: module push into staging
      if (wr_valid && (wr_index < IDX_W'(WORDS))) begin
         next_s.stage[wr_index] = push_word;
         next_s.pend[wr_index] = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s <= '{stage: '0, pend: '0, shown: {WORDS{breaker_pkg::NA_U16}}};
      end else begin
         s <= next_s;
      end
   end

   // never-pushed words read as unsigned not-applicable
   assign rd_data = (rd_index < IDX_W'(WORDS)) ? s.shown[rd_index] : breaker_pkg::NA_U16;
endmodule

// File: bench/breaker_standard_dataset_regs_monitor.sv
// port checker for the dataset register bank
`timescale 1ns/1ps
module breaker_standard_dataset_regs_monitor (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // request
   input wire logic req_valid,
   input wire logic [7:0] req_func,
   input wire logic [15:0] req_addr,
   input wire logic [15:0] req_count,
   input wire logic req_ready,
   // answer
   input wire logic rsp_valid,
   input wire logic rsp_last,
   input wire logic rsp_exc,
   input wire logic [7:0] rsp_exc_code
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   logic tk, rd, ok, e1, e2, e3;
   assign tk = req_valid && req_ready;
   assign rd = req_func == 8'h03 || req_func == 8'h04;
   // legal read: count from 1 to 125
   assign ok = tk && rd && req_count != 16'h0000 && req_count <= 16'h007d;
   assign e1 = rsp_valid && rsp_exc && rsp_exc_code == 8'h01;
   assign e2 = rsp_valid && rsp_exc && rsp_exc_code == 8'h02;
   assign e3 = rsp_valid && rsp_exc && rsp_exc_code == 8'h03;
   property p_func; tk && !rd |=> e1; endproperty
   a_func: assert property (p_func)
      else $error("write not refused");
   property p_cnt; tk && rd && !ok |=> e3; endproperty
   a_cnt: assert property (p_cnt)
      else $error("bad count not refused");
   property p_high; ok && req_addr > 16'h7e54 |=> e2; endproperty
   a_high: assert property (p_high)
      else $error("read above map answered");
   property p_low; ok && req_addr < 16'h0b53 |=> e2; endproperty
   a_low: assert property (p_low)
      else $error("unmapped read answered");
   property p_part; ok && req_addr == 16'h7d63 && req_count < 16'h000c |=> e2; endproperty
   a_part: assert property (p_part)
      else $error("partial block read answered");
   property p_ds; ok && req_addr == 16'h7cff |=> !rsp_valid ##1 rsp_valid && !rsp_exc; endproperty
   a_ds: assert property (p_ds)
      else $error("dataset read not answered");
   property p_pair;
      ok && req_addr == 16'h7cff && req_count == 16'h0002 |=> ##1 !rsp_last ##1 rsp_last;
   endproperty
   a_pair: assert property (p_pair)
      else $error("status pair framing wrong");
   property p_ts;
      ok && req_addr == 16'h0b53 && req_count == 16'h0003 |=> ##1 rsp_valid [*3] ##0 rsp_last;
   endproperty
   a_ts: assert property (p_ts)
      else $error("timestamp read not three words");
   property p_exc; rsp_exc |-> rsp_valid && rsp_last && req_ready; endproperty
   a_exc: assert property (p_exc)
      else $error("exception framing wrong");
   c_ds: cover property (ok && req_addr == 16'h7cff);
   c_ts: cover property (ok && req_addr == 16'h0b53);
   c_exc: cover property (e2);
endmodule
bind breaker_standard_dataset_regs breaker_standard_dataset_regs_monitor i_mon (
   .clk(clk), .reset_n(reset_n), .req_valid(req_valid), .req_func(req_func),
   .req_addr(req_addr), .req_count(req_count), .req_ready(req_ready),
   .rsp_valid(rsp_valid), .rsp_last(rsp_last), .rsp_exc(rsp_exc),
   .rsp_exc_code(rsp_exc_code));

// File: bench/modbus_master_model.sv
// remote master model: issues one read and gathers its answer
`timescale 1ns/1ps
module modbus_master_model (
   // clock
   input wire logic clk,
   // request
   output logic req_valid = 1'b0,
   output logic [7:0] req_func = 8'h00,
   output logic [15:0] req_addr = 16'h0000,
   output logic [15:0] req_count = 16'h0000,
   input wire logic req_ready,
   // answer
   input wire logic rsp_valid,
   input wire logic [15:0] rsp_data,
   input wire logic rsp_last,
   input wire logic rsp_exc,
   input wire logic [7:0] rsp_exc_code
);
   logic [15:0] words [0:127];
   int n_words;
   logic got_exc;
   logic [7:0] exc_code;
   logic timed_out;
   ////////////////
   // count chosen by caller
   task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] c);
      int k;
      n_words = 0;
      got_exc = 1'b0;
      k = 0;
      @(posedge clk);
      req_valid <= 1'b1;
      req_func <= f;
      req_addr <= a;
      req_count <= c;
      // ready judged mid-cycle so the taking edge is known
      do begin
         @(negedge clk);
         k++;
      end while (req_ready !== 1'b1 && k < 300);
      @(posedge clk);
      req_valid <= 1'b0;
      req_func <= ~f;
      req_addr <= ~a;
      req_count <= ~c;
      do begin
         @(negedge clk);
         k++;
         if (rsp_valid === 1'b1) begin
            got_exc = rsp_exc;
            exc_code = rsp_exc_code;
            if (rsp_exc !== 1'b1 && n_words < 128) begin
               words[n_words] = rsp_data;
               n_words++;
            end
         end
      end while (!(rsp_valid === 1'b1 && rsp_last === 1'b1) && k < 600);
      timed_out = k >= 600;
   endtask
endmodule

// File: bench/tb_breaker_standard_dataset_regs.sv
// self-checking bench for the dataset register bank
`timescale 1ns/1ps
`define MM i_modbus_master_model
`define W(i) `MM.words[i]
`define CHK(a, b) begin \
   tests_run++; \
   if ((a) !== (b)) begin \
      n_errors++; \
      $display("[ERR] %0t got %h want %h", $time, a, b); \
   end \
end
module tb_breaker_standard_dataset_regs;
   localparam int CPM = 10;
   localparam int ONE_S = 1000 * CPM;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic req_valid, req_ready, rsp_valid, rsp_last, rsp_exc;
   logic [7:0] req_func, rsp_exc_code;
   logic [15:0] req_addr, req_count, rsp_data;
   logic upd_valid = 1'b0, upd_low_word = 1'b0, upd_out_of_order = 1'b0;
   logic [8:0] upd_index = 9'h000;
   logic [15:0] upd_data = 16'h0000, sys_type = 16'h0001;
   breaker_pkg::data_type_t upd_type = breaker_pkg::DT_U16;
   logic ext_sync = 1'b0, int_sync = 1'b0, position_contact = 1'b0, trip_contact = 1'b0;
   logic [31:0] ext_sync_seconds = 32'h0000_0000;
   logic fault_trip_contact = 1'b0, motor_mechanism = 1'b0;
   logic [2:0] contact_valid = 3'h0;
   int n_errors = 0;
   int tests_run = 0;
   always #2.5 clk = ~clk;
   breaker_standard_dataset_regs #(.CYCLES_PER_MS(CPM)) i_breaker_standard_dataset_regs (.*);
   modbus_master_model i_modbus_master_model (.*);
   ////////////////
   task automatic print_verdict();
      $display("tests_run=%0d n_errors=%0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic rd(input logic [7:0] f, input logic [15:0] a, input logic [15:0] c);
      `MM.xfer(f, a, c);
      `CHK(`MM.timed_out, 1'b0)
   endtask
   task automatic rx(input logic [7:0] f, input logic [15:0] a, input logic [15:0] c,
                     input logic [7:0] e);
      rd(f, a, c);
      `CHK({`MM.got_exc, `MM.exc_code}, {1'b1, e})
   endtask
   task automatic push(input logic [8:0] i, input logic [15:0] d, input logic [1:0] t,
                       input logic lo, input logic oo);
      @(posedge clk);
      upd_valid <= 1'b1;
      upd_index <= i;
      upd_data <= d;
      upd_type <= breaker_pkg::data_type_t'(t);
      upd_low_word <= lo;
      upd_out_of_order <= oo;
   endtask
   ////////////////
   task automatic t_time();
      rd(8'h03, 16'h0b53, 16'h0003);
      `CHK({`W(0), `W(1), `W(2)[14:12]}, 35'h0)
      @(posedge clk);
      ext_sync <= 1'b1;
      int_sync <= 1'b1;
      ext_sync_seconds <= 32'h0001_0002;
      @(posedge clk);
      ext_sync <= 1'b0;
      int_sync <= 1'b0;
      repeat (4) @(posedge clk);
      rd(8'h03, 16'h0b53, 16'h0003);
      `CHK({`W(0), `W(1)}, 32'h0001_0002)
      `CHK(`W(2)[14:12], 3'b111)
      `CHK(`W(2)[11:1], 11'h000)
   endtask
   task automatic t_refuse();
      rx(8'h06, 16'h7d00, 16'h0001, 8'h01);
      rx(8'h10, 16'h7cff, 16'h0002, 8'h01);
      rx(8'h03, 16'h7cff, 16'h0000, 8'h03);
      rx(8'h04, 16'h7cff, 16'h007e, 8'h03);
      rx(8'h03, 16'h7e54, 16'h0002, 8'h02);
      rx(8'h03, 16'h7cfe, 16'h0002, 8'h02);
      rx(8'h03, 16'h0b50, 16'h0004, 8'h02);
      rx(8'h03, 16'h7d63, 16'h000b, 8'h02);
      rx(8'h03, 16'h7d64, 16'h000c, 8'h02);
      rd(8'h03, 16'h7d63, 16'h000c);
      `CHK({`MM.got_exc, `MM.n_words}, {1'b0, 32'd12})
      rd(8'h04, 16'h7d00, 16'h007d);
      `CHK({`MM.got_exc, `MM.n_words}, {1'b0, 32'd125})
   endtask
   task automatic t_status();
      @(posedge clk);
      position_contact <= 1'b1;
      trip_contact <= 1'b1;
      contact_valid <= 3'b101;
      repeat (6) @(posedge clk);
      rd(8'h03, 16'h7cff, 16'h0002);
      `CHK(`W(0), 16'h0005)
      `CHK(`W(1), 16'h0003)
      @(posedge clk);
      position_contact <= 1'b0;
      fault_trip_contact <= 1'b1;
      motor_mechanism <= 1'b1;
      repeat (6) @(posedge clk);
      rd(8'h04, 16'h7d00, 16'h0001);
      `CHK(`W(0), 16'h0004)
   endtask
   task automatic t_neutral();
      @(posedge clk);
      sys_type <= 16'h0000;
      repeat (6) @(posedge clk);
      rd(8'h03, 16'h7d0f, 16'h0001);
      `CHK(`W(0), 16'h8000)
      rd(8'h03, 16'h0cf1, 16'h0001);
      `CHK(`W(0), 16'h0000)
      @(posedge clk);
      sys_type <= 16'h0001;
      repeat (6) @(posedge clk);
      rd(8'h03, 16'h7d0f, 16'h0001);
      `CHK(`W(0), 16'hffff)
   endtask
   task automatic t_push();
      // type codes: 0 u16, 1 s16, 2 s32, 3 f32
      push(9'h020, 16'h1234, 2'd0, 1'b0, 1'b0);
      push(9'h021, 16'h1111, 2'd0, 1'b0, 1'b1);
      push(9'h022, 16'h1111, 2'd1, 1'b0, 1'b1);
      push(9'h023, 16'h1111, 2'd2, 1'b0, 1'b1);
      push(9'h024, 16'h2222, 2'd2, 1'b1, 1'b1);
      push(9'h025, 16'h1111, 2'd3, 1'b0, 1'b1);
      push(9'h026, 16'h2222, 2'd3, 1'b1, 1'b1);
      push(9'h070, 16'hbeef, 2'd0, 1'b0, 1'b0);
      @(posedge clk);
      upd_valid <= 1'b0;
      repeat (ONE_S + 100) @(posedge clk);
      rd(8'h03, 16'h7d1f, 16'h0007);
      `CHK({`W(0), `W(1), `W(2)}, 48'h1234_ffff_8000)
      `CHK({`W(3), `W(4), `W(5), `W(6)}, 64'h8000_0000_ffc0_0000)
      repeat (5 * ONE_S) @(posedge clk);
      rd(8'h03, 16'h7d6f, 16'h0001);
      `CHK(`W(0), 16'hbeef)
   endtask
   initial begin
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      t_time();
      t_refuse();
      t_status();
      t_neutral();
      t_push();
      print_verdict();
   end
   // whole run needs about 60k cycles
   initial begin
      repeat (75000) @(posedge clk);
      n_errors++;
      print_verdict();
   end
endmodule
